// ---- design/ccu_pkg.sv ----
package ccu_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] OFS_CONTROL   = 2'h0;
    localparam logic [1:0] OFS_HOLD_LOW  = 2'h1;
    localparam logic [1:0] OFS_HOLD_HIGH = 2'h2;
    localparam logic [1:0] OFS_STATUS    = 2'h3;

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] HOLD_RST    = 8'h00;

    // Field positions
    localparam int MODE_LSB      = 0;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_OUT_BIT  = 1;

    // Mode codes of the unit mode field
    typedef enum logic [3:0] {
        MODE_OFF      = 4'h0,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_R4   = 4'h6,
        MODE_CAP_R16  = 4'h7,
        MODE_CMP_SET  = 4'h8,
        MODE_CMP_CLR  = 4'h9,
        MODE_CMP_SWI  = 4'hA,
        MODE_CMP_TRIG = 4'hB,
        MODE_CMP_TGL  = 4'h2
    } unit_mode_t;

    // Prescaler counts
    localparam logic [3:0] PRESC_LAST_4  = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hF;

    // Register port request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// ---- design/edge_detect.sv ----
`timescale 1ns/1ps
module edge_detect
    import ccu_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      rise,
    output logic      fall
);
    logic sync1_q;
    logic sync2_q;
    logic last_q;

    // Two-stage synchroniser then history
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            last_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            last_q  <= sync2_q;
        end
    end

    // One pulse per edge
    assign rise = sync2_q & ~last_q;
    assign fall = ~sync2_q & last_q;
endmodule

// ---- design/capture_compare_unit.sv ----
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Behaviour
// RQ1: Software keeps shared timer in timer or synchronized counter mode for capture.
// RQ2: Changing capture mode may raise the event flag spuriously.
// RQ3: Software keeps interrupt disabled while changing mode, then clears flag.
// RQ4: Timer must be clocked by instruction clock or external source.
// RQ5: Prescaler cleared when off, when not capturing, and on reset.
// RQ6: Four prescaler choices; switching between them does not clear prescaler.
// RQ7: Software writes zero to control before selecting a new prescaler.
// RQ8: Timer on instruction clock holds during sleep, resumes after wake.
// RQ9: Capture keeps working during sleep with externally clocked timer.
// RQ10: Compare mode tests holding pair for equality with timer continuously.
// RQ11: Match action by mode: toggle, set, clear, trigger or interrupt only.
// RQ12: Every compare match sets the event flag with the pin action.
// RQ13: Writing zero to control forces compare output latch low.
// RQ14: Software keeps timer synchronous during compare.
// RQ15: Mode 1010 leaves pin uncontrolled and only sets event flag.
// RQ16: Software sets pin direction to output for compare.
// RQ17: Qualifying edge latches timer count into holding pair.
// RQ18: Capture sets flag cleared only by software; later capture overwrites.
// RQ19: Mode 1011 match resets timer next tick and requests converter start.
// RQ20: Edges produced by the port's own output also cause captures.
// RQ21: Pin synchronized before edge detection; one step per edge.
// RQ22: A match acts once per timer value.
module capture_compare_unit
    import ccu_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire reg_req_t    reg_req,
    output logic [7:0]       reg_rdata,
    input  wire logic [15:0] timer_count,
    input  wire logic        timer_tick,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_ctrl,
    output logic             unit_event_flag,
    output logic             timer_reset,
    output logic             converter_start
);
    logic [7:0]  control_q;
    logic [15:0] hold_q;
    logic [3:0]  presc_q;
    logic        flag_q;
    logic        out_q;
    logic        matched_q;
    logic        trig_pend_q;
    logic        trig_q;
    logic [7:0]  rdata_q;
    logic        rise;
    logic        fall;
    logic [3:0]  mode;
    logic        is_capture;
    logic        is_compare;
    logic        cap_step;
    logic        capture;
    logic        match;
    logic        match_new;
    logic        wr_ctl;
    logic        wr_lo;
    logic        wr_hi;
    logic        flag_clr;

    assign mode = control_q[MODE_LSB +: 4];
    assign is_capture = (mode[3:2] == 2'b01);
    assign is_compare = (mode[3] == 1'b1) || (mode == MODE_CMP_TGL);

    // Address decode of writes
    always_comb
    begin
        wr_ctl   = 1'b0;
        wr_lo    = 1'b0;
        wr_hi    = 1'b0;
        flag_clr = 1'b0;
        if (reg_req.wr && reg_req.addr == OFS_CONTROL)
            wr_ctl = 1'b1;
        else if (reg_req.wr && reg_req.addr == OFS_HOLD_LOW)
            wr_lo = 1'b1;
        else if (reg_req.wr && reg_req.addr == OFS_HOLD_HIGH)
            wr_hi = 1'b1;
        else if (reg_req.wr && reg_req.addr == OFS_STATUS)
            flag_clr = reg_req.wdata[STAT_FLAG_BIT];
    end

    // RQ21 synchronised edges
    // RQ20 pin read back includes own drive
    edge_detect u_edge (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin_in  (pin_in),
        .rise    (rise),
        .fall    (fall)
    );

    // Control register
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            control_q <= CONTROL_RST;
        else if (wr_ctl)
            control_q <= reg_req.wdata;
    end

    // RQ5 prescaler clearing
    // RQ6 mode switch keeps count
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            presc_q <= 4'h0;
        else if (!is_capture)
            presc_q <= 4'h0;
        else if (rise && (mode == MODE_CAP_R4 || mode == MODE_CAP_R16))
            presc_q <= presc_q + 4'h1;
    end

    // RQ17 qualifying event select
    always_comb
    begin
        cap_step = 1'b0;
        case (mode)
            MODE_CAP_FALL: cap_step = fall;
            MODE_CAP_RISE: cap_step = rise;
            MODE_CAP_R4:   cap_step = rise && (presc_q[1:0] == PRESC_LAST_4[1:0]);
            MODE_CAP_R16:  cap_step = rise && (presc_q == PRESC_LAST_16);
            default:       cap_step = 1'b0;
        endcase
    end
    assign capture = cap_step;

    // RQ10 continuous equality
    assign match = is_compare && (timer_count == hold_q);
    // RQ22 once per timer value
    assign match_new = match && !matched_q;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            matched_q <= 1'b0;
        else
            matched_q <= match;
    end

    // RQ17 latch timer; RQ18 overwrite; RQ9 runs on any timer source
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            hold_q <= {HOLD_RST, HOLD_RST};
        else if (capture)
            hold_q <= timer_count;
        else if (wr_lo)
            hold_q[7:0] <= reg_req.wdata;
        else if (wr_hi)
            hold_q[15:8] <= reg_req.wdata;
    end

    // RQ18 sticky flag, set wins
    // RQ12 compare match sets flag
    // RQ2 mode change may show a capture edge
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            flag_q <= 1'b0;
        else if (capture || match_new)
            flag_q <= 1'b1;
        else if (flag_clr)
            flag_q <= 1'b0;
    end

    // RQ11 pin action on match
    // RQ13 zero control clears latch
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            out_q <= 1'b0;
        else if (mode == MODE_OFF)
            out_q <= 1'b0;
        else if (match_new)
        begin
            case (mode)
                MODE_CMP_TGL: out_q <= ~out_q;
                MODE_CMP_SET: out_q <= 1'b1;
                MODE_CMP_CLR: out_q <= 1'b0;
                default:      out_q <= out_q;
            endcase
        end
    end

    // RQ15 pin driven only in pin modes
    assign pin_ctrl = (mode == MODE_CMP_TGL) || (mode == MODE_CMP_SET) || (mode == MODE_CMP_CLR);
    assign pin_out  = out_q;
    assign unit_event_flag = flag_q;

    // RQ19 trigger pulse and timer reset on next tick
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            trig_q      <= 1'b0;
            trig_pend_q <= 1'b0;
        end
        else
        begin
            trig_q <= match_new && (mode == MODE_CMP_TRIG);
            if (match_new && mode == MODE_CMP_TRIG)
                trig_pend_q <= 1'b1;
            else if (timer_tick || !match)
                trig_pend_q <= 1'b0;
        end
    end

    // RQ8 timer reset only on a real timer tick
    assign timer_reset     = trig_pend_q && match && timer_tick;
    assign converter_start = trig_q;

    // Read data one cycle after strobe
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rdata_q <= 8'h00;
        else if (reg_req.rd)
        begin
            if (reg_req.addr == OFS_CONTROL)
                rdata_q <= control_q;
            else if (reg_req.addr == OFS_HOLD_LOW)
                rdata_q <= hold_q[7:0];
            else if (reg_req.addr == OFS_HOLD_HIGH)
                rdata_q <= hold_q[15:8];
            else
                rdata_q <= {6'h00, out_q, flag_q};
        end
        else
            rdata_q <= 8'h00;
    end
    assign reg_rdata = rdata_q;

    // Assertions
    // RQ5 prescaler cleared
    presc_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ5
        !is_capture |=> presc_q == 4'h0) else $error("prescaler not cleared");
    // RQ18 flag set by capture
    cap_flag_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ18
        capture |=> flag_q) else $error("capture did not set flag");
    // RQ17 holding value latched
    cap_latch_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ17
        capture |=> hold_q == $past(timer_count)) else $error("capture value wrong");
    // RQ12 compare flag
    cmp_flag_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ12
        match_new |=> flag_q) else $error("match did not set flag");
    // RQ13 zero control lowers latch
    off_low_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ13
        (wr_ctl && reg_req.wdata == 8'h00) |=> ##1 !out_q) else $error("latch not cleared");
    // RQ15 software interrupt leaves pin
    swi_pin_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ15
        mode == MODE_CMP_SWI |-> !pin_ctrl ##1 $stable(out_q)) else $error("pin touched in mode 1010");
    // RQ19 converter start follows match
    trig_start_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ19
        (match_new && mode == MODE_CMP_TRIG) |=> converter_start) else $error("no converter start");
    // RQ22 single action per value
    once_match_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ22
        (match && matched_q) |=> $stable(out_q)) else $error("match acted twice");
    // RQ11 set mode drives high
    set_high_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ11
        (match_new && mode == MODE_CMP_SET && !wr_ctl) |=> out_q) else $error("set mode did not set");
    // RQ11 clear mode drives low
    clr_low_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ11
        (match_new && mode == MODE_CMP_CLR) |=> !out_q) else $error("clear mode did not clear");
    // RQ11 toggle mode inverts
    tgl_flip_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ11
        (match_new && mode == MODE_CMP_TGL) |=> out_q != $past(out_q)) else $error("toggle mode did not toggle");
    // RQ18 software clear
    flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ18
        (flag_clr && !capture && !match_new) |=> !flag_q) else $error("flag not cleared");
    // RQ18 set beats clear
    set_wins_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ18
        (flag_clr && capture) |=> flag_q) else $error("clear beat capture");
    // RQ17 rising edge capture
    rise_cap_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ17
        (mode == MODE_CAP_RISE && rise) |-> capture) else $error("rising edge not captured");
    // RQ17 falling edge capture
    fall_cap_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ17
        (mode == MODE_CAP_FALL && fall) |-> capture) else $error("falling edge not captured");
    // RQ17 sixteenth edge only
    r16_skip_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ17
        (mode == MODE_CAP_R16 && rise && presc_q != PRESC_LAST_16) |-> !capture) else $error("early capture");
    // RQ17 hold kept without event
    hold_keep_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ17
        (!capture && !wr_lo && !wr_hi) |=> $stable(hold_q)) else $error("holding pair changed");
    // RQ19 trigger leaves pin alone
    trig_pin_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ19
        mode == MODE_CMP_TRIG |-> !pin_ctrl) else $error("pin driven in mode 1011");
    // RQ22 one converter start
    conv_once_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ22
        converter_start |=> !converter_start) else $error("converter start repeated");
    // RQ19 timer reset ends pending request
    reset_once_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ19
        timer_reset |=> !trig_pend_q) else $error("timer reset still pending");

    // Trigger match, then waiting for the next timer tick
    sequence trig_seen;
        match_new && mode == MODE_CMP_TRIG;
    endsequence
    sequence pend_wait;
        trig_pend_q && match && !timer_tick;
    endsequence
    // RQ8 reset waits for a tick
    trig_wait_a: assert property (@(posedge clk_sys) disable iff (reset) // RQ8
        trig_seen ##1 pend_wait |=> trig_pend_q) else $error("pending reset lost before tick");
endmodule

// ---- dv/pin_partner.sv ----
`timescale 1ns/1ps
// Far side of the event pin: outside source, or the unit's own drive
module pin_partner (
    input  wire logic ext_level,
    input  wire logic pin_out,
    input  wire logic pin_ctrl,
    output logic      pin_in
);
    // pin direction, own drive
    // Pin set as output while the unit drives it; else the outside level
    assign pin_in = pin_ctrl ? pin_out : ext_level;
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
    import ccu_pkg::*;
;
    logic        clk_sys, reset, timer_tick, ext_level;
    logic        pin_in, pin_out, pin_ctrl, flag, trst, conv;
    reg_req_t    req;
    logic [7:0]  rdata;
    logic [15:0] tcount;
    int          failures, n_checks, n_conv, n_trst, n_pin;
    unit_mode_t  cap_m[4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_R4, MODE_CAP_R16};
    int          cap_n[4] = '{1, 1, 4, 16};
    unit_mode_t  cmp_m[5] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_TGL, MODE_CMP_SWI, MODE_CMP_TRIG};
    // Expected {latch, drive enable, one latch change}
    logic [2:0]  cmp_e[5] = '{3'h7, 3'h3, 3'h7, 3'h4, 3'h4};

    capture_compare_unit i_capture_compare_unit (
        .clk_sys(clk_sys), .reset(reset), .reg_req(req), .reg_rdata(rdata),
        .timer_count(tcount), .timer_tick(timer_tick), .pin_in(pin_in),
        .pin_out(pin_out), .pin_ctrl(pin_ctrl), .unit_event_flag(flag),
        .timer_reset(trst), .converter_start(conv));

    pin_partner i_pin_partner (.ext_level(ext_level), .pin_out(pin_out), .pin_ctrl(pin_ctrl), .pin_in(pin_in));

    // Clock, 5 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Pulse and latch change counters
    always @(posedge clk_sys)
    begin
        if (conv === 1'b1) n_conv <= n_conv + 1;
        if (trst === 1'b1) n_trst <= n_trst + 1;
    end
    always @(pin_out) n_pin++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // Read, data taken in the cycle after the strobe
    task automatic rchk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask

    // timer ticks synchronous, slower than clk_sys
    task automatic tick(input logic [15:0] v);
        @(posedge clk_sys);
        tcount <= v;
        timer_tick <= 1'b1;
        @(posedge clk_sys);
        timer_tick <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic pulse;
        @(posedge clk_sys);
        ext_level <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_level <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic cap_mode(input logic [3:0] m);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, {4'h0, m});
        wr(OFS_STATUS, 8'h01);
    endtask

    task automatic results;
        if (failures == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog against a hang
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        failures++;
        results();
    end

    initial
    begin
        reset = 1'b1;
        req = '0;
        tcount = 16'h0000;
        timer_tick = 1'b0;
        ext_level = 1'b0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rchk(OFS_CONTROL, CONTROL_RST);
        rchk(OFS_HOLD_LOW, HOLD_RST);
        rchk(OFS_HOLD_HIGH, HOLD_RST);
        rchk(OFS_STATUS, 8'h00);
        // Each capture choice with its own edge count
        foreach (cap_m[i])
        begin
            tcount <= 16'hA5C0 + 16'(i);
            cap_mode(cap_m[i]);
            repeat (cap_n[i] - 1) pulse();
            #1 chk(16'(flag), 16'h0000);
            pulse();
            chk(16'(flag), 16'h0001);
            rchk(OFS_HOLD_LOW, 8'hC0 + 8'(i));
            rchk(OFS_HOLD_HIGH, 8'hA5);
        end
        // Partial prescale count is dropped when the unit is off
        cap_mode(MODE_CAP_R4);
        repeat (2) pulse();
        cap_mode(MODE_CAP_R4);
        repeat (3) pulse();
        chk(16'(flag), 16'h0000);
        pulse();
        chk(16'(flag), 16'h0001);
        // Later capture overwrites, flag stays until cleared
        cap_mode(MODE_CAP_RISE);
        pulse();
        tcount <= 16'h0F0E;
        pulse();
        rchk(OFS_HOLD_LOW, 8'h0E);
        rchk(OFS_HOLD_HIGH, 8'h0F);
        rchk(OFS_STATUS, 8'h01);
        wr(OFS_STATUS, 8'h01);
        #1 chk(16'(flag), 16'h0000);
        // Compare actions, value held for several cycles
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_HOLD_LOW, 8'h10);
        wr(OFS_HOLD_HIGH, 8'h00);
        foreach (cmp_m[i])
        begin
            tick(16'h000F);
            wr(OFS_CONTROL, {4'h0, cmp_m[i]});
            wr(OFS_STATUS, 8'h01);
            n_pin = 0;
            #1 chk(16'(flag), 16'h0000);
            tick(16'h0010);
            chk(16'(flag), 16'h0001);
            chk({13'h0, pin_out, pin_ctrl, n_pin == 1}, {13'h0, cmp_e[i]});
        end
        chk(16'(n_conv), 16'h0001);
        chk(16'(n_trst), 16'h0000);
        tick(16'h0010);
        chk(16'(n_trst), 16'h0001);
        chk(16'(n_conv), 16'h0001);
        wr(OFS_CONTROL, 8'h00);
        @(posedge clk_sys);
        #1 chk(16'(pin_out), 16'h0000);
        results();
    end
endmodule
